// ==== pdcc_partner.sv ====
// CPU core and interrupt pin model
`default_nettype none
module pdcc_partner (
   input  wire logic clk, halt_cmd, wake_cmd, CPU_CLK_EN,
   output var logic  CPU_HALT_REQ, EXT_IRQ_ZERO_N
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      CPU_HALT_REQ = 0;
      EXT_IRQ_ZERO_N = 1;
   end
   // Halt only runs while the core is clocked
   always @(posedge clk) begin
      CPU_HALT_REQ <= halt_cmd && CPU_CLK_EN && !CPU_HALT_REQ;
      EXT_IRQ_ZERO_N <= !wake_cmd;
   end
endmodule // pdcc_partner
`default_nettype wire

// ==== pdcc_power_down.v ====
// Power-down mode controller with clock prescaler and settle-wait timer
//
// Overview of operation
// R01: A prescaler chain gives enables at system clock over 2 up to 4096.
// R02: At 5 MHz or more the oscillator duty cycle is corrected first.
// R03: Halt with standby select 0 enters sleep; clock and modules keep running.
// R04: Halt with standby select 1 enters software standby; clock, CPU, modules stop.
// R05: Low hardware standby pin forces hardware standby from any state.
// R06: Standby select stays 1 after interrupt wake; only a software write clears it. Here reset and hardware standby also clear it.
// R07: Settle field picks 8192 to 131072 states; 11x illegal; resets to 000.
// R08: Software picks a settle wait of at least 8 ms with a crystal.
// R09: Software clears RAM enable before the standby pin goes low.
// R10: System control holds standby select at bit 7, settle wait at 6:4.
// R11: Sleep ends on an enabled interrupt, reset pin or standby pin.
// R12: Software standby ends on NMI, either external IRQ, reset or standby pin.
// R13: Interrupt wake restarts oscillator, waits settle time, then resupplies clocks.
// R14: Standby pin rises under reset; reset release then starts reset handling.
// R15: Settle timer counts states and releases clocks only at the selected count.
// R16: The illegal settle setting is treated as the longest wait.
//
// The strobed register port was left to the implementer.
`default_nettype none
`include "pdcc_regs.vh"

// Two-flop synchroniser for one asynchronous pin
module pdcc_sync2 #(
   parameter [0:0] IDLE = 1'b1
) (
   // Clock and reset
   input  wire sys_clk,
   input  wire resetn,
   // Pin and synchronised level
   input  wire pin,
   output wire level
);

   reg         first;
   reg         second;

   // Reset loads the pin's idle level so no false edge follows reset
   always @(posedge sys_clk) begin
      if (!resetn) begin
         first  <= IDLE;
         second <= IDLE;
      end else begin
         first  <= pin;
         second <= first;
      end
   end

   // Only the second stage leaves the module, so nothing reads a metastable value
   assign level = second;

endmodule // pdcc_sync2

module pdcc_power_down #(
   parameter [17:0] WAIT_SCALE_SHIFT = 18'h00000
) (
   // Clock and reset
   input  wire        SYS_CLK,
   input  wire        RESETN,
   // Register port
   input  wire [15:0] ADDR,
   input  wire [7:0]  WDATA,
   input  wire        WR,
   input  wire        RD,
   output reg  [7:0]  RDATA,
   // CPU core
   input  wire        CPU_HALT_REQ,
   input  wire        CPU_IRQ_PENDING,
   output wire        CPU_CLK_EN,
   output wire        MOD_CLK_EN,
   output wire        MOD_RESET,
   output wire        CPU_IRQ_HANDLE,
   output wire        CPU_RESET_HANDLE,
   // External pins
   input  wire        HW_STANDBY_PIN_N,
   input  wire        NMI_PIN,
   input  wire        EXT_IRQ_ZERO_N,
   input  wire        EXT_IRQ_ONE_N,
   input  wire        EXT_IRQ_ZERO_EN,
   input  wire        EXT_IRQ_ONE_EN,
   // Clock generation and status
   output wire        OSC_RUN,
   output wire        DUTY_ADJ_EN,
   output wire [11:0] PRESC_EN,
   output wire        PORTS_HIZ,
   output wire        RAM_ENABLE,
   output wire [4:0]  MODE
);

   // One-hot power modes
   localparam [4:0] ST_RUN    = 5'b00001;
   localparam [4:0] ST_SLEEP  = 5'b00010;
   localparam [4:0] ST_SWSTBY = 5'b00100;
   localparam [4:0] ST_SETTLE = 5'b01000;
   localparam [4:0] ST_HWSTBY = 5'b10000;

   // State and register storage
   reg  [4:0]  state;
   reg  [4:0]  next_state;
   reg  [7:0]  sysctl;
   reg  [17:0] settle_cnt;
   reg  [17:0] settle_target;
   reg  [11:0] presc;
   reg  [11:0] presc_pulse;
   reg         irq_wake;
   reg         nmi_d;
   // Synchronised pin levels and prescaler taps
   wire        hw_standby_pin_n_n;
   wire        nmi_lvl;
   wire        ext_irq_zero_lvl_n;
   wire        ext_irq_one_lvl_n;
   wire [11:0] presc_tap;
   wire        nmi_rise  = nmi_lvl & ~nmi_d;
   // External request pins wake software standby only while enabled
   wire        ext_irq_zero_wake = ~ext_irq_zero_lvl_n & EXT_IRQ_ZERO_EN;
   wire        ext_irq_one_wake = ~ext_irq_one_lvl_n & EXT_IRQ_ONE_EN;
   wire        ext_wake  = nmi_rise | ext_irq_zero_wake | ext_irq_one_wake;
   // Register decode
   wire        hw_standby_pin_n_sel  = sysctl[`PDCC_STBYSEL_BIT];
   wire [2:0]  settle_sel = sysctl[`PDCC_SETTLE_HI:`PDCC_SETTLE_LO];
   wire        wr_hit    = WR && (ADDR == `PDCC_SYSCTL_ADDR);
   wire        rd_hit    = RD && (ADDR == `PDCC_SYSCTL_ADDR);
   wire        settle_done = (settle_cnt >= settle_target);
   wire        fast_osc  = (`PDCC_SYS_CLK_KHZ >= `PDCC_FAST_OSC_KHZ);

   // Every pin but EXT_IRQ_ZERO_EN and EXT_IRQ_ONE_EN crosses two flip-flops before the sequencer looks at it
   pdcc_sync2 #(.IDLE(1'b1)) pdcc_sync2_hw_standby_pin_n_i (
      .sys_clk (SYS_CLK),
      .resetn  (RESETN),
      .pin     (HW_STANDBY_PIN_N),
      .level   (hw_standby_pin_n_n)
   );

   pdcc_sync2 #(.IDLE(1'b0)) pdcc_sync2_nmi_i (
      .sys_clk (SYS_CLK),
      .resetn  (RESETN),
      .pin     (NMI_PIN),
      .level   (nmi_lvl)
   );

   pdcc_sync2 #(.IDLE(1'b1)) pdcc_sync2_ext_irq_zero_i (
      .sys_clk (SYS_CLK),
      .resetn  (RESETN),
      .pin     (EXT_IRQ_ZERO_N),
      .level   (ext_irq_zero_lvl_n)
   );

   pdcc_sync2 #(.IDLE(1'b1)) pdcc_sync2_ext_irq_one_i (
      .sys_clk (SYS_CLK),
      .resetn  (RESETN),
      .pin     (EXT_IRQ_ONE_N),
      .level   (ext_irq_one_lvl_n)
   );

   // Edge memory of the non-maskable pin; reset low to match its idle level
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         nmi_d <= 1'b0;
      end else begin
         nmi_d <= nmi_lvl;
      end
   end

   // Settle target from field; 11x takes the longest wait
   always @* begin
      case (settle_sel)
         3'b000:  settle_target = `PDCC_WAIT_0; // R07
         3'b001:  settle_target = `PDCC_WAIT_1; // R07
         3'b010:  settle_target = `PDCC_WAIT_2; // R07
         3'b011:  settle_target = `PDCC_WAIT_3; // R07
         default: settle_target = `PDCC_WAIT_4; // R07 R16
      endcase
      settle_target = settle_target >> WAIT_SCALE_SHIFT;
      if (settle_target == 18'h00000) begin
         settle_target = 18'h00001;
      end
   end

   // Mode sequencer
   always @* begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (CPU_HALT_REQ) begin
               next_state = hw_standby_pin_n_sel ? ST_SWSTBY : ST_SLEEP; // R03 R04
            end
         end
         ST_SLEEP: begin
            if (CPU_IRQ_PENDING || nmi_rise) begin
               next_state = ST_RUN; // R11
            end
         end
         ST_SWSTBY: begin
            if (ext_wake) begin
               next_state = ST_SETTLE; // R12 R13
            end
         end
         ST_SETTLE: begin
            if (settle_done) begin
               next_state = ST_RUN; // R15
            end
         end
         ST_HWSTBY: begin
            next_state = ST_HWSTBY;
         end
         default: next_state = ST_RUN;
      endcase
      if (!hw_standby_pin_n_n) begin
         next_state = ST_HWSTBY; // R05 R11 R12
      end
   end

   // Mode register, wake pulse and settle counter
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         state      <= ST_RUN;
         settle_cnt <= 18'h00000;
         irq_wake   <= 1'b0;
      end else begin
         state      <= next_state;
         irq_wake   <= (state == ST_SETTLE) && (next_state == ST_RUN); // R13
         // Counter restarts at one so the settle mode lasts exactly the target count
         if (state == ST_SETTLE) begin
            settle_cnt <= settle_cnt + 18'h00001; // R15
         end else begin
            settle_cnt <= 18'h00001;
         end
      end
   end

   // Hardware standby is left only through reset: flag the first cycle after release
   reg reset_seen;
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         reset_seen <= 1'b1;
      end else begin
         reset_seen <= 1'b0;
      end
   end
   wire reset_entry = reset_seen;

   // System control register; hardware standby returns it to its reset value
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         sysctl <= `PDCC_SYSCTL_RESET; // R07
      end else if (state == ST_HWSTBY) begin
         sysctl <= `PDCC_SYSCTL_RESET;
      end else if (wr_hit) begin
         sysctl <= (WDATA & `PDCC_WRMASK) | (`PDCC_SYSCTL_RESET & ~`PDCC_WRMASK); // R06 R10
      end
   end

   // Read port: data stand for one cycle only
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         RDATA <= 8'h00;
      end else if (rd_hit) begin
         RDATA <= sysctl; // R10
      end else begin
         RDATA <= 8'h00;
      end
   end

   // Tap i fires when the low i+1 counter bits are all ones, once every 2^(i+1) cycles
   genvar g;
   generate
      for (g = 0; g < 12; g = g + 1) begin : g_presc_tap
         assign presc_tap[g] = &presc[g:0]; // R01
      end
   endgenerate

   // Prescaler chain; halted and reset in both standby modes
   always @(posedge SYS_CLK) begin
      if (!RESETN || state == ST_SWSTBY || state == ST_SETTLE || state == ST_HWSTBY) begin
         presc       <= 12'h000;
         presc_pulse <= 12'h000;
      end else begin
         presc       <= presc + 12'h001; // R01
         presc_pulse <= presc_tap; // R01
      end
   end

   // Module clocks run in program execution and sleep
   wire clocks_on = (state == ST_RUN) || (state == ST_SLEEP);

   // Outputs
   assign CPU_CLK_EN       = (state == ST_RUN); // R03
   assign MOD_CLK_EN       = clocks_on; // R03 R04
   assign MOD_RESET        = (state == ST_SWSTBY) || (state == ST_HWSTBY); // R04 R05
   assign OSC_RUN          = (state != ST_SWSTBY) && (state != ST_HWSTBY); // R13
   assign DUTY_ADJ_EN      = fast_osc && OSC_RUN; // R02
   assign PRESC_EN         = presc_pulse;
   assign PORTS_HIZ        = (state == ST_HWSTBY); // R05
   assign RAM_ENABLE       = sysctl[`PDCC_RAMEN_BIT];
   assign CPU_IRQ_HANDLE   = irq_wake;
   assign CPU_RESET_HANDLE = reset_entry; // R14
   assign MODE             = state;

endmodule // pdcc_power_down
`default_nettype wire

// ==== pdcc_power_down_tb.sv ====
// Testbench of the power-down clock controller
`default_nettype none
module pdcc_power_down_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic SYS_CLK = 0, RESETN = 0, WR = 0, RD = 0, NMI_PIN = 0, EXT_IRQ_ONE_N = 1, HW_STANDBY_PIN_N = 1;
   logic EXT_IRQ_ZERO_EN = 1, EXT_IRQ_ONE_EN = 1, CPU_IRQ_PENDING = 0, halt = 0, wake = 0;
   logic [15:0] ADDR = 0;
   logic [7:0] WDATA = 0, rv;
   logic [31:0] seed = 41;
   wire CPU_HALT_REQ, EXT_IRQ_ZERO_N, CPU_CLK_EN, MOD_CLK_EN, MOD_RESET, CPU_IRQ_HANDLE, CPU_RESET_HANDLE;
   wire OSC_RUN, DUTY_ADJ_EN, PORTS_HIZ, RAM_ENABLE;
   wire [11:0] PRESC_EN;
   wire [4:0] MODE;
   wire [7:0] RDATA;
   int errors = 0, checks_done = 0, n, settle_n = 0, irq_n = 0;
   pdcc_power_down #(.WAIT_SCALE_SHIFT(18'h0000A)) pdcc_power_down_i (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
      .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CPU_HALT_REQ(CPU_HALT_REQ),
      .CPU_IRQ_PENDING(CPU_IRQ_PENDING), .CPU_CLK_EN(CPU_CLK_EN), .MOD_CLK_EN(MOD_CLK_EN), .MOD_RESET(MOD_RESET),
      .CPU_IRQ_HANDLE(CPU_IRQ_HANDLE), .CPU_RESET_HANDLE(CPU_RESET_HANDLE), .HW_STANDBY_PIN_N(HW_STANDBY_PIN_N),
      .NMI_PIN(NMI_PIN), .EXT_IRQ_ZERO_N(EXT_IRQ_ZERO_N), .EXT_IRQ_ONE_N(EXT_IRQ_ONE_N),
      .EXT_IRQ_ZERO_EN(EXT_IRQ_ZERO_EN), .EXT_IRQ_ONE_EN(EXT_IRQ_ONE_EN), .OSC_RUN(OSC_RUN),
      .DUTY_ADJ_EN(DUTY_ADJ_EN), .PRESC_EN(PRESC_EN), .PORTS_HIZ(PORTS_HIZ), .RAM_ENABLE(RAM_ENABLE), .MODE(MODE));
   pdcc_partner pdcc_partner_i (.clk(SYS_CLK), .halt_cmd(halt), .wake_cmd(wake), .CPU_CLK_EN(CPU_CLK_EN),
      .CPU_HALT_REQ(CPU_HALT_REQ), .EXT_IRQ_ZERO_N(EXT_IRQ_ZERO_N));
   initial forever #20 SYS_CLK = ~SYS_CLK;
   always @(posedge SYS_CLK) if (MODE === 5'h08) settle_n <= settle_n + 1;
   always @(posedge SYS_CLK) if (CPU_IRQ_HANDLE === 1'b1) irq_n <= irq_n + 1;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   function automatic int exp_wait(input int k);
      return (8192 << (k > 4 ? 4 : k)) >> 10;
   endfunction
   task automatic conclude;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k = 1);
      repeat (k) @(posedge SYS_CLK);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      WR <= 1; ADDR <= a; WDATA <= d; tick; WR <= 0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      RD <= 1; ADDR <= a; tick; RD <= 0; @(negedge SYS_CLK); d = RDATA; tick;
   endtask
   task automatic wait_mode(input logic [4:0] m);
      n = 0;
      while (MODE !== m && n < 300) begin @(negedge SYS_CLK); n++; end
      chk(MODE, m);
      if (n >= 300) conclude;
      tick;
   endtask
   initial begin
      tick(16); RESETN <= 1; tick(3);
      rd(16'hFFF2, rv); chk(rv, 8'h0B);
      wr(16'hFFF0, 8'h00); rd(16'hFFF0, rv); chk(rv, 8'h00);
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed); wr(16'hFFF2, seed[7:0]); rd(16'hFFF2, rv); chk(rv, seed[7:0] & 8'hFB);
      end
      $display("register test done");
      wr(16'hFFF2, 8'h0B); halt <= 1; tick; halt <= 0;
      wait_mode(5'h02);
      CPU_IRQ_PENDING <= 1; wait_mode(5'h01); CPU_IRQ_PENDING <= 0;
      $display("sleep test done");
      for (int k = 0; k < 8; k++) begin
         wr(16'hFFF2, {1'b1, k[2:0], 4'hB}); halt <= 1; tick; halt <= 0;
         wait_mode(5'h04); settle_n <= 0; irq_n <= 0;
         case (k % 3) 0: wake <= 1; 1: EXT_IRQ_ONE_N <= 0; default: NMI_PIN <= 1; endcase
         wait_mode(5'h01); chk(settle_n, exp_wait(k));
         wake <= 0; EXT_IRQ_ONE_N <= 1; NMI_PIN <= 0;
         rd(16'hFFF2, rv); chk(rv[7], 1'b1);
         chk(irq_n, 1);
         $display("standby test %0d done", k);
      end
      wr(16'hFFF2, 8'h0A); rd(16'hFFF2, rv); chk(RAM_ENABLE, 1'b0);
      HW_STANDBY_PIN_N <= 0; wait_mode(5'h10); chk(PORTS_HIZ, 1'b1);
      RESETN <= 0; tick(2); HW_STANDBY_PIN_N <= 1; tick(4); RESETN <= 1;
      @(negedge SYS_CLK); chk(CPU_RESET_HANDLE, 1'b1);
      wait_mode(5'h01); rd(16'hFFF2, rv); chk(rv, 8'h0B);
      chk(CPU_RESET_HANDLE, 1'b0);
      $display("pin standby test done");
      n = 0;
      while (PRESC_EN[11] !== 1'b1 && n < 5000) begin @(negedge SYS_CLK); n++; end
      n = 1; @(negedge SYS_CLK);
      while (PRESC_EN[11] !== 1'b1 && n < 5000) begin @(negedge SYS_CLK); n++; end
      chk(n, 4096);
      $display("prescaler test done");
      conclude;
   end
endmodule // pdcc_power_down_tb
`default_nettype wire

// ==== pdcc_props.sv ====
// Assertion checker for the power-down clock controller
`default_nettype none
module pdcc_props (
   // Clock, reset and register port
   input wire logic        SYS_CLK, RESETN, RD,
   input wire logic [15:0] ADDR,
   input wire logic [7:0]  RDATA,
   // Core side and pins
   input wire logic        CPU_HALT_REQ, HW_STANDBY_PIN_N, CPU_IRQ_HANDLE, CPU_RESET_HANDLE,
   // Clock and mode outputs
   input wire logic        CPU_CLK_EN, MOD_CLK_EN, MOD_RESET, OSC_RUN, DUTY_ADJ_EN, PORTS_HIZ,
   input wire logic [11:0] PRESC_EN,
   input wire logic [4:0]  MODE
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   sequence s_halt; HW_STANDBY_PIN_N [*3] ##0 MODE == 5'h01 && CPU_HALT_REQ; endsequence
   sequence s_settled; MODE == 5'h08 ##1 MODE == 5'h01; endsequence
   AST_HALT: assert property (s_halt |=> MODE == 5'h02 || MODE == 5'h04)
      else $error("halt not taken");
   AST_SLEEP: assert property (MODE == 5'h02 |-> MOD_CLK_EN && OSC_RUN && !CPU_CLK_EN)
      else $error("sleep clocks wrong");
   AST_SWSTBY: assert property (MODE == 5'h04 |-> MOD_RESET && !OSC_RUN && !MOD_CLK_EN)
      else $error("standby clocks wrong");
   AST_HWSTBY: assert property (!HW_STANDBY_PIN_N [*5] |-> MODE == 5'h10 && PORTS_HIZ)
      else $error("pin standby not entered");
   AST_PRESC: assert property (PRESC_EN[0] |=> !PRESC_EN[0])
      else $error("divide by two enable too long");
   AST_RDATA: assert property (!(RD && ADDR == 16'hFFF2) |=> RDATA == 8'h00)
      else $error("read data without read");
   AST_DUTY: assert property (DUTY_ADJ_EN == OSC_RUN)
      else $error("duty correction off");
   AST_WAKE: assert property (s_settled |-> ##[0:1] CPU_IRQ_HANDLE)
      else $error("no interrupt handling");
   AST_RSTH: assert property ($rose(RESETN) |-> CPU_RESET_HANDLE)
      else $error("no reset handling");
endmodule // pdcc_props
bind pdcc_power_down pdcc_props pdcc_props_i (
   .SYS_CLK(SYS_CLK), .RESETN(RESETN), .RD(RD), .ADDR(ADDR), .RDATA(RDATA),
   .CPU_HALT_REQ(CPU_HALT_REQ), .HW_STANDBY_PIN_N(HW_STANDBY_PIN_N), .CPU_IRQ_HANDLE(CPU_IRQ_HANDLE),
   .CPU_RESET_HANDLE(CPU_RESET_HANDLE), .CPU_CLK_EN(CPU_CLK_EN), .MOD_CLK_EN(MOD_CLK_EN), .MOD_RESET(MOD_RESET),
   .OSC_RUN(OSC_RUN), .DUTY_ADJ_EN(DUTY_ADJ_EN), .PORTS_HIZ(PORTS_HIZ), .PRESC_EN(PRESC_EN), .MODE(MODE)
);
`default_nettype wire

// ==== pdcc_regs.vh ====
// Register map, field positions, reset values and timing counts of the power-down clock controller
`ifndef PDCC_REGS_VH
`define PDCC_REGS_VH
`define PDCC_SYSCTL_ADDR     16'hFFF2
`define PDCC_SYSCTL_RESET    8'h0B
`define PDCC_STBYSEL_BIT     7
`define PDCC_SETTLE_HI       6
`define PDCC_SETTLE_LO       4
`define PDCC_RAMEN_BIT       0
`define PDCC_WRMASK          8'hFB
`define PDCC_WAIT_0          18'h02000
`define PDCC_WAIT_1          18'h04000
`define PDCC_WAIT_2          18'h08000
`define PDCC_WAIT_3          18'h10000
`define PDCC_WAIT_4          18'h20000
`define PDCC_PRESC_W         12
`define PDCC_FAST_OSC_KHZ    5000
`define PDCC_SYS_CLK_KHZ     25000
`endif
